//--- fbsc_pkg.sv
// constants and types shared by the fieldbus slave state control files
package fbsc_pkg;

	// timing
	localparam int CLK_NS = 50;
	localparam logic [31:0] TIME_STEP = 32'(CLK_NS);
	localparam int MS_NS = 1000000;
	localparam int TICK_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;

	// command byte bit positions
	localparam int CMD_WR = 0;
	localparam int CMD_RD = 1;
	localparam int CMD_CFG = 2;

	// telegram header byte positions
	localparam logic [3:0] H_CMD = 4'h0;
	localparam logic [3:0] H_ADP0 = 4'h2;
	localparam logic [3:0] H_ADP1 = 4'h3;
	localparam logic [3:0] H_ADO0 = 4'h4;
	localparam logic [3:0] H_ADO1 = 4'h5;
	localparam logic [3:0] H_LEN0 = 4'h6;
	localparam logic [3:0] H_LEN1 = 4'h7;
	localparam logic [3:0] H_IRQ1 = 4'h9;
	localparam int LEN_MORE = 7;

	// node configuration space, byte offsets below CFG_TOP
	localparam logic [15:0] CFG_TOP = 16'h0010;
	localparam logic [3:0] C_STA0 = 4'h0;
	localparam logic [3:0] C_STA1 = 4'h1;
	localparam logic [3:0] C_STATE_REQ = 4'h2;
	localparam logic [3:0] C_FAULT = 4'h3;
	localparam logic [3:0] C_WDOG0 = 4'h4;
	localparam logic [3:0] C_WDOG1 = 4'h5;
	localparam logic [3:0] C_STATUS = 4'h6;
	localparam logic [3:0] C_DRIFT = 4'h7;
	localparam logic [3:0] C_OFS0 = 4'h8;
	localparam logic [3:0] C_OFS1 = 4'h9;
	localparam logic [3:0] C_OFS2 = 4'ha;
	localparam logic [3:0] C_OFS3 = 4'hb;
	localparam logic [3:0] C_TS0 = 4'hc;
	localparam int STATUS_ERR = 4;
	localparam int FAULT_ZERO_VEL = 0;
	localparam logic [15:0] FAULT_OBJ_INDEX = 16'h2011;
	localparam logic [7:0] FAULT_OBJ_SUB = 8'h06;
	localparam logic [31:0] RST_VALUE = 32'h0;

	// sync manager windows: addr[15:10] selects, addr[9:8] is the channel
	localparam logic [5:0] SM_HI = 6'h04;
	localparam logic [1:0] SM_MBX_OUT = 2'h0;
	localparam logic [1:0] SM_MBX_IN = 2'h1;
	localparam logic [1:0] SM_PD_OUT = 2'h2;
	localparam logic [1:0] SM_PD_IN = 2'h3;

	// state request and status codes
	localparam logic [7:0] REQ_INIT = 8'h01;
	localparam logic [7:0] REQ_PREOP = 8'h02;
	localparam logic [7:0] REQ_BOOT = 8'h03;
	localparam logic [7:0] REQ_SAFEOP = 8'h04;
	localparam logic [7:0] REQ_OP = 8'h08;

	// emergency codes
	localparam logic [7:0] EMCY_DRIVE = 8'h01;
	localparam logic [7:0] EMCY_WDOG = 8'h02;
	localparam logic [7:0] EMCY_STATE = 8'h03;

	// forwarding buffer
	localparam int FIFO_W = 9;
	localparam int FIFO_D = 16;

	typedef enum logic [1:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP} fbsc_state_t;
	typedef enum logic [2:0] {P_HDR, P_DATA, P_WKC0, P_WKC1, P_SKIP} fbsc_parse_t;

endpackage

//--- fbsc_fifo.sv
// forwarding fifo with registered output stage
`timescale 1ns/100ps
`default_nettype none
module fbsc_fifo #(
	parameter int W = 9,
	parameter int D = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output wire logic in_ready,
	// drain side
	output wire logic out_valid,
	output wire logic [W-1:0] out_data,
	input wire logic out_ready
);

	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic rdy;
		logic ov;
		logic [W-1:0] od;
	} fbsc_fifo_t;

	fbsc_fifo_t q;
	fbsc_fifo_t n;
	logic push;
	logic load;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = q;
		push = in_valid & q.rdy;
		load = (q.cnt != '0) & (~q.ov | out_ready);
		if (q.ov & out_ready) begin
			n.ov = 1'b0;
		end
		if (load) begin
			n.od = q.mem[q.rp];
			n.ov = 1'b1;
			n.rp = q.rp + AW'(1);
		end
		if (push) begin
			n.mem[q.wp] = in_data;
			n.wp = q.wp + AW'(1);
		end
		n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(load);
		// ready is a flop so the upstream sees back-pressure without a path
		n.rdy = n.cnt < (AW+1)'(D);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0;
			q.rdy <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign in_ready = q.rdy;
	assign out_valid = q.ov;
	assign out_data = q.od;

endmodule
`default_nettype wire

//--- fbsc_slave.sv
// fieldbus slave: on-the-fly telegram processing and state control
`timescale 1ns/100ps
`default_nettype none
// Function
// R01 - edit passing frame bytes, forward them quickly
// R02 - last node sends frame back
// R03 - sixteen bit addresses cover whole population
// R04 - answer position address, increment while passing
// R05 - answer only programmed station address
// R06 - parse header, data, counter; chained telegrams
// R07 - count only addressed telegrams with exchange
// R08 - four channels, committed per complete telegram
// R09 - output watchdog drops Operational to Safe
// R10 - fault flag picks passive or zero velocity
// R11 - start Init, move only on request
// R12 - bootstrap requests are refused
// R13 - Init: no mailbox, no process data
// R14 - Pre-operational: mailbox only
// R15 - Safe-operational: inputs sent, outputs refused
// R16 - master enables outputs via Operational
// R17 - master configures before Safe-operational
// R18 - emergency message on module or drive fault; code sends no EMCY_DRIVE in a cycle that raises EMCY_WDOG or EMCY_STATE
// R19 - cyclic process data, acyclic mailbox data
// R20 - network write latches local time stamp
// R21 - apply written offset plus drift correction
// R22 - master picks the reference clock
// R23 - refuse skipping or unknown transitions
module fbsc_slave #(
	parameter int TICK_CYC = fbsc_pkg::TICK_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// frame in from upstream port
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	output wire logic rx_ready,
	// frame out, forward or return
	input wire logic out_link_up,
	output wire logic fwd_valid,
	input wire logic fwd_ready,
	output wire logic ret_valid,
	input wire logic ret_ready,
	output wire logic [7:0] tx_data,
	output wire logic tx_last,
	// application memory
	output wire logic app_wr_valid,
	output wire logic [1:0] app_wr_chan,
	output wire logic [7:0] app_wr_addr,
	output wire logic [7:0] app_wr_data,
	output wire logic [1:0] app_rd_chan,
	output wire logic [7:0] app_rd_addr,
	input wire logic [7:0] app_rd_data,
	output wire logic [3:0] sm_commit,
	// state, drive and time
	output wire fbsc_pkg::fbsc_state_t al_state,
	input wire logic drive_fault,
	output wire logic drive_passive,
	output wire logic drive_zero_vel,
	output wire logic emcy_valid,
	output wire logic [7:0] emcy_code,
	output wire logic [31:0] sys_time
);

	typedef struct packed {
		logic [2:0] sync;
		logic fault_st;
		fbsc_pkg::fbsc_state_t st;
		logic err;
		fbsc_pkg::fbsc_parse_t pst;
		logic [3:0] hc;
		logic [7:0] cmd;
		logic [7:0] adp0;
		logic carry;
		logic hit;
		logic [7:0] len0;
		logic more;
		logic [10:0] dcnt;
		logic [15:0] addr;
		logic xchg;
		logic [3:0] touch;
		logic [3:0] commit;
		logic [15:0][7:0] cfg;
		logic [31:0] ts;
		logic [31:0] local_t;
		logic [31:0] corr;
		logic [31:0] sys_t;
		logic [31:0] tick;
		logic [15:0] wd;
		logic passive;
		logic zero_vel;
		logic emcy_v;
		logic [7:0] emcy_c;
		logic wr_v;
		logic [1:0] wr_ch;
		logic [7:0] wr_a;
		logic [7:0] wr_d;
		logic fv;
		logic rv;
		logic ret;
		logic mid;
		logic [7:0] od;
		logic ol;
	} fbsc_slave_t;

	fbsc_slave_t q;
	fbsc_slave_t n;
	logic fire;
	logic [7:0] ob;
	logic [7:0] rb;
	logic [2:0] tr;
	logic in_cfg;
	logic in_sm;
	logic [1:0] ch;
	logic [3:0] ci;
	logic do_wr;
	logic do_rd;
	logic tick_now;
	logic busy;
	logic f_valid;
	logic [8:0] f_data;
	logic f_rdy;
	logic route;

	////////////////////////////////////////////////////////////////////////
	// bootstrap and unknown codes fall to default and are refused
	function automatic logic [2:0] fbsc_trans(
		input fbsc_pkg::fbsc_state_t cur,
		input logic [7:0] req
	);
		logic ok;
		fbsc_pkg::fbsc_state_t nx;
		ok = 1'b0;
		nx = cur;
		case (req)
			fbsc_pkg::REQ_INIT: begin
				ok = 1'b1;
				nx = fbsc_pkg::ST_INIT;
			end
			fbsc_pkg::REQ_PREOP: begin
				ok = 1'b1;
				nx = fbsc_pkg::ST_PREOP;
			end
			fbsc_pkg::REQ_SAFEOP: begin
				ok = cur != fbsc_pkg::ST_INIT;
				nx = ok ? fbsc_pkg::ST_SAFEOP : cur;
			end
			fbsc_pkg::REQ_OP: begin
				ok = (cur == fbsc_pkg::ST_SAFEOP) || (cur == fbsc_pkg::ST_OP);
				nx = ok ? fbsc_pkg::ST_OP : cur;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return {ok, nx};
	endfunction

	function automatic logic [7:0] fbsc_code(input fbsc_pkg::fbsc_state_t s);
		case (s)
			fbsc_pkg::ST_PREOP: return fbsc_pkg::REQ_PREOP;
			fbsc_pkg::ST_SAFEOP: return fbsc_pkg::REQ_SAFEOP;
			fbsc_pkg::ST_OP: return fbsc_pkg::REQ_OP;
			default: return fbsc_pkg::REQ_INIT;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = q;
		ob = rx_data;
		rb = 8'h00;
		tr = 3'h0;
		fire = rx_valid & rx_ready;
		in_cfg = q.addr < fbsc_pkg::CFG_TOP;
		in_sm = q.addr[15:10] == fbsc_pkg::SM_HI;
		ch = q.addr[9:8];
		ci = q.addr[3:0];
		do_wr = 1'b0;
		do_rd = 1'b0;
		n.sync = {q.sync[1:0], drive_fault};
		if (q.sync[1] == q.sync[2]) begin
			n.fault_st = q.sync[2];
		end
		n.emcy_v = 1'b0;
		n.wr_v = 1'b0;
		n.commit = 4'h0;
		// time base with master offset and per-ms drift step
		n.local_t = q.local_t + fbsc_pkg::TIME_STEP;
		n.sys_t = q.local_t + q.corr; // see R21
		tick_now = q.tick == 32'(TICK_CYC - 1);
		n.tick = tick_now ? 32'h0 : q.tick + 32'h1;
		if (tick_now) begin
			n.corr = q.corr + {{24{q.cfg[fbsc_pkg::C_DRIFT][7]}},
				q.cfg[fbsc_pkg::C_DRIFT]}; // see R21
			if (q.st == fbsc_pkg::ST_OP) begin
				n.wd = q.wd + 16'h1;
			end
		end

		if (fire) begin
			case (q.pst)
				fbsc_pkg::P_HDR: begin
					n.hc = q.hc + 4'h1;
					case (q.hc)
						fbsc_pkg::H_CMD: begin
							n.cmd = rx_data;
						end
						fbsc_pkg::H_ADP0: begin
							n.adp0 = rx_data;
							n.carry = rx_data == 8'hff;
							if (!q.cmd[fbsc_pkg::CMD_CFG]) begin
								ob = rx_data + 8'h01; // see R04
							end
						end
						fbsc_pkg::H_ADP1: begin
							if (q.cmd[fbsc_pkg::CMD_CFG]) begin
								n.hit = {rx_data, q.adp0} ==
									{q.cfg[fbsc_pkg::C_STA1],
									q.cfg[fbsc_pkg::C_STA0]}; // see R05 R03
							end else begin
								ob = rx_data + {7'h00, q.carry};
								n.hit = {rx_data, q.adp0} == 16'h0000; // see R04
							end
						end
						fbsc_pkg::H_ADO0: begin
							n.addr[7:0] = rx_data;
						end
						fbsc_pkg::H_ADO1: begin
							n.addr[15:8] = rx_data;
						end
						fbsc_pkg::H_LEN0: begin
							n.len0 = rx_data;
						end
						fbsc_pkg::H_LEN1: begin
							n.dcnt = {rx_data[2:0], q.len0};
							n.more = rx_data[fbsc_pkg::LEN_MORE]; // see R06
						end
						fbsc_pkg::H_IRQ1: begin
							n.hc = 4'h0;
							n.xchg = 1'b0;
							n.pst = (q.dcnt == 11'h000) ? fbsc_pkg::P_WKC0 :
								fbsc_pkg::P_DATA; // see R06
						end
						default: begin
						end
					endcase
				end
				fbsc_pkg::P_DATA: begin
					// mailbox from Pre-op, outputs only in Op, inputs from Safe-op
					do_wr = q.hit & q.cmd[fbsc_pkg::CMD_WR] & (in_cfg | in_sm &
						((ch == fbsc_pkg::SM_MBX_OUT && q.st != fbsc_pkg::ST_INIT) ||
						(ch == fbsc_pkg::SM_PD_OUT && q.st == fbsc_pkg::ST_OP)));
						// see R13 R14 R15 R16 R19
					do_rd = q.hit & q.cmd[fbsc_pkg::CMD_RD] & (in_cfg | in_sm &
						((ch == fbsc_pkg::SM_MBX_IN && q.st != fbsc_pkg::ST_INIT) ||
						(ch == fbsc_pkg::SM_PD_IN &&
						(q.st == fbsc_pkg::ST_SAFEOP || q.st == fbsc_pkg::ST_OP))));
						// see R13 R14 R15 R19
					if (ci == fbsc_pkg::C_STATUS) begin
						rb = fbsc_code(q.st);
						rb[fbsc_pkg::STATUS_ERR] = q.err;
					end else if (ci >= fbsc_pkg::C_TS0) begin
						// stamp bytes are aligned so ci[1:0] is the byte lane
						rb = q.ts[{ci[1:0], 3'b000} +: 8];
					end else begin
						rb = q.cfg[ci];
					end
					if (do_rd) begin
						ob = in_cfg ? rb : app_rd_data; // see R01
					end
					if (do_wr & in_cfg) begin
						if (ci == fbsc_pkg::C_STATE_REQ) begin
							n.cfg[ci] = rx_data;
							tr = fbsc_trans(q.st, rx_data); // see R11 R12 R23
							if (tr[2]) begin
								n.st = fbsc_pkg::fbsc_state_t'(tr[1:0]);
								n.err = 1'b0;
								if (tr[1:0] == 2'(fbsc_pkg::ST_OP) &&
									q.st != fbsc_pkg::ST_OP) begin
									n.wd = 16'h0000;
									n.passive = 1'b0;
									n.zero_vel = 1'b0;
								end
							end else begin
								n.err = 1'b1; // see R23
								n.emcy_v = 1'b1;
								n.emcy_c = fbsc_pkg::EMCY_STATE;
							end
						end else if (ci == fbsc_pkg::C_TS0) begin
							n.ts = q.local_t; // see R20
						end else if (ci != fbsc_pkg::C_STATUS && ci < fbsc_pkg::C_TS0) begin
							n.cfg[ci] = rx_data;
						end
						if (ci == fbsc_pkg::C_OFS3) begin
							n.corr = {rx_data, q.cfg[fbsc_pkg::C_OFS2],
								q.cfg[fbsc_pkg::C_OFS1], q.cfg[fbsc_pkg::C_OFS0]};
								// see R21
						end
					end
					if (do_wr & in_sm) begin
						n.wr_v = 1'b1;
						n.wr_ch = ch;
						n.wr_a = q.addr[7:0];
						n.wr_d = rx_data;
					end
					if ((do_wr | do_rd) & in_sm) begin
						n.touch[ch] = 1'b1; // see R08
					end
					if (do_wr | do_rd) begin
						n.xchg = 1'b1; // see R07
					end
					n.addr = q.addr + 16'h0001;
					n.dcnt = q.dcnt - 11'h001;
					if (q.dcnt == 11'h001) begin
						n.pst = fbsc_pkg::P_WKC0;
					end
				end
				fbsc_pkg::P_WKC0: begin
					ob = rx_data + {7'h00, q.xchg}; // see R07
					n.carry = q.xchg & (rx_data == 8'hff);
					n.pst = fbsc_pkg::P_WKC1;
				end
				fbsc_pkg::P_WKC1: begin
					ob = rx_data + {7'h00, q.carry};
					// buffers change hands only once the telegram is whole
					n.commit = q.touch; // see R08
					n.touch = 4'h0;
					if (q.touch[fbsc_pkg::SM_PD_OUT]) begin
						n.wd = 16'h0000; // see R09
					end
					n.pst = q.more ? fbsc_pkg::P_HDR : fbsc_pkg::P_SKIP; // see R06
				end
				fbsc_pkg::P_SKIP: begin
				end
				default: begin
					n.pst = fbsc_pkg::P_HDR;
				end
			endcase
			// a truncated telegram is dropped without committing
			if (rx_last) begin
				n.pst = fbsc_pkg::P_HDR;
				n.hc = 4'h0;
				n.touch = 4'h0;
			end
		end

		// watchdog after the parser so it sees a same-cycle request
		if (n.st == fbsc_pkg::ST_OP &&
			{q.cfg[fbsc_pkg::C_WDOG1], q.cfg[fbsc_pkg::C_WDOG0]} != 16'h0000 &&
			n.wd >= {q.cfg[fbsc_pkg::C_WDOG1], q.cfg[fbsc_pkg::C_WDOG0]}) begin
			n.st = fbsc_pkg::ST_SAFEOP; // see R09
			n.wd = 16'h0000;
			n.zero_vel = q.cfg[fbsc_pkg::C_FAULT][fbsc_pkg::FAULT_ZERO_VEL]; // see R10
			n.passive = ~q.cfg[fbsc_pkg::C_FAULT][fbsc_pkg::FAULT_ZERO_VEL]; // see R10
			n.emcy_v = 1'b1; // see R18
			n.emcy_c = fbsc_pkg::EMCY_WDOG;
		end else if (n.fault_st & ~q.fault_st & ~n.emcy_v) begin
			n.emcy_v = 1'b1; // see R18
			n.emcy_c = fbsc_pkg::EMCY_DRIVE;
		end

		// output stage, route fixed for the whole frame
		busy = q.fv | q.rv;
		if (busy & (q.ret ? ret_ready : fwd_ready)) begin
			n.fv = 1'b0;
			n.rv = 1'b0;
		end
		f_rdy = ~busy | (q.ret ? ret_ready : fwd_ready);
		route = q.mid ? q.ret : ~out_link_up; // see R02
		if (f_valid & f_rdy) begin
			n.ret = route;
			n.fv = ~route; // see R01
			n.rv = route; // see R02
			n.od = f_data[7:0];
			n.ol = f_data[8];
			n.mid = ~f_data[8];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			q <= '0; // see R11
		end else begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// the short fifo keeps the pass-through delay far under 4 us
	fbsc_fifo #(
		.W(fbsc_pkg::FIFO_W),
		.D(fbsc_pkg::FIFO_D)
	) u_fifo (
		.clk(clk),
		.reset(reset),
		.in_valid(rx_valid),
		.in_data({rx_last, ob}),
		.in_ready(rx_ready),
		.out_valid(f_valid),
		.out_data(f_data),
		.out_ready(f_rdy)
	); // see R01

	assign fwd_valid = q.fv;
	assign ret_valid = q.rv;
	assign tx_data = q.od;
	assign tx_last = q.ol;
	assign app_wr_valid = q.wr_v;
	assign app_wr_chan = q.wr_ch;
	assign app_wr_addr = q.wr_a;
	assign app_wr_data = q.wr_d;
	assign app_rd_chan = q.addr[9:8];
	assign app_rd_addr = q.addr[7:0];
	assign sm_commit = q.commit;
	assign al_state = q.st;
	assign drive_passive = q.passive;
	assign drive_zero_vel = q.zero_vel;
	assign emcy_valid = q.emcy_v;
	assign emcy_code = q.emcy_c;
	assign sys_time = q.sys_t;

endmodule
`default_nettype wire

//--- fbsc_far_end.sv
// downstream consumer and application memory model for the slave bench
`timescale 1ns/100ps
`default_nettype none
module fbsc_far_end (
	// clock
	input wire logic clk,
	// frame out of the slave
	input wire logic fwd_valid,
	input wire logic ret_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic fwd_ready,
	output logic ret_ready,
	// application memory
	input wire logic [1:0] app_rd_chan,
	input wire logic [7:0] app_rd_addr,
	output logic [7:0] app_rd_data
);
	logic [1:0] cnt_q = 2'h0;
	logic [9:0] got[$];
	// stall one cycle in four so held bytes are exercised
	assign fwd_ready = cnt_q != 2'h3;
	assign ret_ready = cnt_q != 2'h3;
	// same-cycle answer, tagged by channel so a wrong channel shows
	assign app_rd_data = {app_rd_chan, app_rd_addr[5:0]};
	always @(posedge clk) begin
		cnt_q <= cnt_q + 2'h1;
		if (fwd_valid && fwd_ready)
			got.push_back({1'b0, tx_last, tx_data});
		if (ret_valid && ret_ready)
			got.push_back({1'b1, tx_last, tx_data});
	end
endmodule
`default_nettype wire

//--- fbsc_slave_checker.sv
// concurrent checks on the fieldbus slave ports
`timescale 1ns/100ps
`default_nettype none
module fbsc_slave_checker #(
	parameter int TICK_CYC = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// frame out
	input wire logic fwd_valid,
	input wire logic fwd_ready,
	input wire logic ret_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	// application side
	input wire logic app_wr_valid,
	input wire logic [1:0] app_wr_chan,
	input wire logic [3:0] sm_commit,
	// state and drive
	input wire fbsc_pkg::fbsc_state_t al_state,
	input wire logic drive_passive,
	input wire logic drive_zero_vel,
	input wire logic emcy_valid,
	input wire logic [7:0] emcy_code
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_fwd_wait;
		fwd_valid && !fwd_ready;
	endsequence
	sequence s_enter_op;
		al_state != fbsc_pkg::ST_OP ##1 al_state == fbsc_pkg::ST_OP;
	endsequence
	sequence s_wdog;
		emcy_valid && emcy_code == fbsc_pkg::EMCY_WDOG;
	endsequence
	AST_INIT_AFTER_RESET:
		assert property ($past(reset) |-> al_state == fbsc_pkg::ST_INIT)
		else $error("state not init after reset");
	AST_FWD_HOLD:
		assert property (s_fwd_wait |=> fwd_valid && $stable(tx_data)
			&& $stable(tx_last)) else $error("forward byte not held");
	AST_ONE_WAY:
		assert property (!(fwd_valid && ret_valid))
		else $error("both directions valid");
	AST_COMMIT_PULSE:
		assert property (sm_commit != 4'h0 |=> sm_commit == 4'h0)
		else $error("commit longer than one cycle");
	AST_INIT_NO_WR:
		assert property (app_wr_valid |-> $past(al_state) != fbsc_pkg::ST_INIT)
		else $error("application write in init");
	AST_PDO_OP_ONLY:
		assert property (app_wr_valid && app_wr_chan == fbsc_pkg::SM_PD_OUT
			|-> $past(al_state) == fbsc_pkg::ST_OP)
		else $error("output write outside operational");
	AST_NO_SKIP_OP:
		assert property (s_enter_op |-> $past(al_state) == fbsc_pkg::ST_SAFEOP)
		else $error("operational entered without safe state");
	AST_REFUSE_KEEPS:
		assert property (emcy_valid && emcy_code == fbsc_pkg::EMCY_STATE
			|-> $stable(al_state)) else $error("refused request moved state");
	AST_WDOG_DROP:
		assert property (s_wdog |-> al_state == fbsc_pkg::ST_SAFEOP
			&& $past(al_state) == fbsc_pkg::ST_OP
			&& drive_passive != drive_zero_vel)
		else $error("watchdog reaction wrong");
	AST_OP_CLEARS:
		assert property (s_enter_op |-> ##[0:1] !drive_passive && !drive_zero_vel)
		else $error("drive reaction kept in operational");
endmodule
bind fbsc_slave fbsc_slave_checker #(.TICK_CYC(TICK_CYC)) chk_u (
	.clk(clk), .reset(reset), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready),
	.ret_valid(ret_valid), .tx_data(tx_data), .tx_last(tx_last),
	.app_wr_valid(app_wr_valid), .app_wr_chan(app_wr_chan),
	.sm_commit(sm_commit), .al_state(al_state),
	.drive_passive(drive_passive), .drive_zero_vel(drive_zero_vel),
	.emcy_valid(emcy_valid), .emcy_code(emcy_code)
);
`default_nettype wire

//--- fbsc_slave_bench.sv
// self-checking bench for the fieldbus slave state control
`timescale 1ns/100ps
`default_nettype none
module fbsc_slave_bench;
	localparam int TICK = 20;
	localparam logic [7:0] WR = 8'h01;
	localparam logic [7:0] RD = 8'h02;
	localparam logic [7:0] WR_CFG = 8'h05;
	localparam logic [15:0] A_REQ = {12'h000, fbsc_pkg::C_STATE_REQ};
	localparam logic [15:0] A_MBX = {fbsc_pkg::SM_HI, fbsc_pkg::SM_MBX_OUT, 8'h00};
	localparam logic [15:0] A_PDO = {fbsc_pkg::SM_HI, fbsc_pkg::SM_PD_OUT, 8'h00};
	localparam logic [15:0] A_PDI = {fbsc_pkg::SM_HI, fbsc_pkg::SM_PD_IN, 8'h00};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic rx_valid = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic rx_last = 1'b0;
	logic out_link_up = 1'b1;
	logic drive_fault = 1'b0;
	wire logic rx_ready, fwd_valid, fwd_ready, ret_valid, ret_ready, tx_last;
	wire logic app_wr_valid, drive_passive, drive_zero_vel, emcy_valid;
	wire logic [7:0] tx_data, app_rd_addr, app_rd_data, emcy_code;
	wire logic [7:0] app_wr_addr, app_wr_data;
	wire logic [1:0] app_rd_chan, app_wr_chan;
	wire logic [3:0] sm_commit;
	wire logic [31:0] sys_time;
	wire fbsc_pkg::fbsc_state_t al_state;
	logic [7:0] tel[13];
	logic [7:0] emcy_seen = 8'h00;
	logic [17:0] wr_seen = 18'h00000;
	logic [3:0] commit_seen = 4'h0;
	int miscompares = 0;
	int n_compared = 0;
	int n_wr = 0;
	int cycles = 0;
	initial forever #25 clk = ~clk;
	fbsc_slave #(.TICK_CYC(TICK)) dut_u (
		.clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_last(rx_last), .rx_ready(rx_ready), .out_link_up(out_link_up),
		.fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .ret_valid(ret_valid),
		.ret_ready(ret_ready), .tx_data(tx_data), .tx_last(tx_last),
		.app_wr_valid(app_wr_valid), .app_wr_chan(app_wr_chan),
		.app_wr_addr(app_wr_addr), .app_wr_data(app_wr_data),
		.app_rd_chan(app_rd_chan), .app_rd_addr(app_rd_addr),
		.app_rd_data(app_rd_data), .sm_commit(sm_commit), .al_state(al_state),
		.drive_fault(drive_fault), .drive_passive(drive_passive),
		.drive_zero_vel(drive_zero_vel), .emcy_valid(emcy_valid),
		.emcy_code(emcy_code), .sys_time(sys_time)
	);
	fbsc_far_end far_u (
		.clk(clk), .fwd_valid(fwd_valid), .ret_valid(ret_valid),
		.tx_data(tx_data), .fwd_ready(fwd_ready), .ret_ready(ret_ready),
		.tx_last(tx_last),
		.app_rd_chan(app_rd_chan), .app_rd_addr(app_rd_addr),
		.app_rd_data(app_rd_data)
	);
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (emcy_valid === 1'b1)
			emcy_seen <= emcy_code;
		if (app_wr_valid === 1'b1) begin
			n_wr <= n_wr + 1;
			wr_seen <= {app_wr_chan, app_wr_addr, app_wr_data};
		end
		// outputs are unknown before the first reset edge
		if (!reset)
			commit_seen <= commit_seen | sm_commit;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// one telegram with one data byte; working counter enters as 0x00ff
	// so a count also tests the carry into the high byte
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] adp,
			input logic [15:0] ado, input logic [7:0] d, input logic [7:0] ed,
			input logic inc);
		logic [15:0] ea;
		logic [15:0] ew;
		logic ok;
		ea = cmd[fbsc_pkg::CMD_CFG] ? adp : adp + 16'h0001;
		ew = 16'h00ff + {15'h0000, inc};
		tel = '{cmd, 8'h00, adp[7:0], adp[15:8], ado[7:0], ado[15:8], 8'h01,
			8'h00, 8'h00, 8'h00, d, 8'hff, 8'h00};
		far_u.got.delete();
		@(posedge clk);
		for (int i = 0; i < 13; i++) begin
			rx_valid <= 1'b1;
			rx_data <= tel[i];
			rx_last <= i == 12;
			do begin
				@(negedge clk);
				ok = rx_ready;
				@(posedge clk);
			end while (ok !== 1'b1);
		end
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		tel[2] = ea[7:0];
		tel[3] = ea[15:8];
		tel[10] = ed;
		tel[11] = ew[7:0];
		tel[12] = ew[15:8];
		for (int i = 0; i < 200 && far_u.got.size() < 13; i++)
			@(negedge clk);
		for (int i = 0; i < 13; i++)
			chk("frame byte", {~out_link_up, i == 12, tel[i]},
				far_u.got[i]);
	endtask
	task automatic req(input logic [7:0] code, input logic inc);
		xfer(WR, 16'h0000, A_REQ, code, code, inc);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		@(negedge clk);
		chk("state", fbsc_pkg::ST_INIT, al_state);
		chk("forward valid", 16'h0000, fwd_valid);
		$display("test reset done");
	endtask
	task automatic t_states();
		xfer(WR, 16'h0000, A_MBX, 8'h11, 8'h11, 1'b0);
		chk("writes", 16'h0000, n_wr);
		req(fbsc_pkg::REQ_PREOP, 1'b1);
		chk("state", fbsc_pkg::ST_PREOP, al_state);
		req(fbsc_pkg::REQ_BOOT, 1'b1);
		chk("emcy", fbsc_pkg::EMCY_STATE, emcy_seen);
		xfer(RD, 16'h0000, 16'h0006, 8'h00, 8'h12, 1'b1);
		req(fbsc_pkg::REQ_OP, 1'b1);
		chk("state", fbsc_pkg::ST_PREOP, al_state);
		xfer(WR, 16'h0000, A_MBX, 8'h22, 8'h22, 1'b1);
		chk("writes", 16'h0001, n_wr);
		chk("write", {fbsc_pkg::SM_MBX_OUT, 16'h0022}, wr_seen);
		$display("test states done");
	endtask
	task automatic t_station();
		xfer(WR, 16'hffff, A_REQ, 8'h01, 8'h01, 1'b0);
		xfer(WR, 16'h0000, 16'h0000, 8'h05, 8'h05, 1'b1);
		xfer(WR_CFG, 16'h0006, A_REQ, 8'h04, 8'h04, 1'b0);
		chk("state", fbsc_pkg::ST_PREOP, al_state);
		xfer(WR_CFG, 16'h0005, A_REQ, 8'h04, 8'h04, 1'b1);
		chk("state", fbsc_pkg::ST_SAFEOP, al_state);
		xfer(WR, 16'h0000, A_PDO, 8'h33, 8'h33, 1'b0);
		xfer(RD, 16'h0000, A_PDI, 8'h00, 8'hc0, 1'b1);
		chk("writes", 16'h0001, n_wr);
		$display("test station done");
	endtask
	task automatic t_op();
		req(fbsc_pkg::REQ_OP, 1'b1);
		chk("state", fbsc_pkg::ST_OP, al_state);
		xfer(WR, 16'h0000, A_PDO, 8'h44, 8'h44, 1'b1);
		chk("writes", 16'h0002, n_wr);
		chk("write", {fbsc_pkg::SM_PD_OUT, 16'h0044}, wr_seen);
		chk("commit", 16'h000d, commit_seen);
		xfer(WR, 16'h0000, 16'h0004, 8'h01, 8'h01, 1'b1);
		repeat (100) @(negedge clk);
		chk("state", fbsc_pkg::ST_SAFEOP, al_state);
		chk("emcy", fbsc_pkg::EMCY_WDOG, emcy_seen);
		chk("passive", 16'h0001, drive_passive);
		xfer(WR, 16'h0000, 16'h0003, 8'h01, 8'h01, 1'b1);
		req(fbsc_pkg::REQ_OP, 1'b1);
		repeat (100) @(negedge clk);
		chk("zero velocity", 16'h0001, drive_zero_vel);
		chk("passive", 16'h0000, drive_passive);
		$display("test operational done");
	endtask
	task automatic t_tail();
		@(posedge clk);
		drive_fault <= 1'b1;
		repeat (10) @(negedge clk);
		chk("emcy", fbsc_pkg::EMCY_DRIVE, emcy_seen);
		@(posedge clk);
		drive_fault <= 1'b0;
		out_link_up <= 1'b0;
		xfer(WR, 16'h0000, A_MBX, 8'h55, 8'h55, 1'b1);
		$display("test fault and return done");
	endtask
	// this node acts as the reference: the bench, as master, loads its offset
	task automatic t_time();
		logic [31:0] s0;
		int c0;
		@(negedge clk);
		s0 = sys_time;
		c0 = cycles;
		xfer(WR, 16'h0000, 16'h000b, 8'h01, 8'h01, 1'b1);
		chk("time offset", 32'(cycles - c0) * fbsc_pkg::TIME_STEP +
			32'h01000000, sys_time - s0);
		xfer(WR, 16'h0000, 16'h0007, 8'h02, 8'h02, 1'b1);
		s0 = sys_time;
		// a window of whole ticks holds exactly five drift steps
		repeat (5 * TICK) @(negedge clk);
		chk("time drift", 32'(5 * TICK) * fbsc_pkg::TIME_STEP + 32'h0000000a,
			sys_time - s0);
		$display("test time done");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_states();
		t_station();
		t_op();
		t_tail();
		t_time();
		report_and_stop();
	end
endmodule
`default_nettype wire
